// [tth_regs.svh]
`ifndef TTH_REGS_SVH
`define TTH_REGS_SVH

// Register select decode
`define TTH_SEL_DATA 1'b0
`define TTH_SEL_CTRL 1'b1

// First control register bits
`define TTH_CF_TONE_OUT 0
`define TTH_CF_CP_MODE 1
`define TTH_CF_IRQ_EN 2
`define TTH_CF_BANK_SEL 3

// Second control register bits
`define TTH_CS_BURST_N 0
`define TTH_CS_RX_PWR 1
`define TTH_CS_SINGLE 2
`define TTH_CS_GROUP 3

// Status register bits
`define TTH_ST_IRQ 0
`define TTH_ST_TX_EMPTY 1
`define TTH_ST_RX_FULL 2
`define TTH_ST_STEER 3

// Reset values
`define TTH_CTRL_RST 4'h0
`define TTH_DIGIT_RST 4'h0

// Timing
`define TTH_CLK_KHZ 25000
`define TTH_BURST_TIME_MS 51
`define TTH_BURST_CYCLES (`TTH_BURST_TIME_MS * `TTH_CLK_KHZ)
`define TTH_BURST_CNT_W 22

`endif

// [tth_pkg.sv]
package tth_pkg;

    typedef enum logic {
        TTH_STYLE_STROBE = 1'b0,
        TTH_STYLE_SPLIT = 1'b1
    } tth_style_t;

    typedef enum logic [1:0] {
        TTH_BT_IDLE = 2'b00,
        TTH_BT_TONE = 2'b01,
        TTH_BT_PAUSE = 2'b10
    } tth_burst_state_t;

    typedef struct packed {
        logic cs_n;
        logic strobe_or_read;
        logic rw_or_write_n;
        logic register_select_line;
        logic [3:0] data;
    } tth_bus_in_t;

    typedef struct packed {
        logic valid;
        logic [3:0] code;
        logic steering;
        logic cp_square;
    } tth_rx_in_t;

    typedef struct packed {
        logic tone_on;
        logic tx_power_down;
        logic [3:0] digit;
        logic single_tone;
        logic high_group;
        logic rx_power_down;
        logic call_progress;
    } tth_tone_ctrl_t;

endpackage

// [tth_burst_timer.sv]
`timescale 1ns/1ps
`include "tth_regs.svh"

module tth_burst_timer #(
    parameter int unsigned BURST_CYCLES = `TTH_BURST_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic i_double,
    output logic o_tone_on,
    output logic o_busy,
    output logic o_done
);
    import tth_pkg::*;

    localparam logic [`TTH_BURST_CNT_W-1:0] LEN =
        `TTH_BURST_CNT_W'(BURST_CYCLES - 1);

    typedef struct packed {
        tth_burst_state_t st;
        logic [`TTH_BURST_CNT_W-1:0] cnt;
        logic done;
    } tth_bt_reg_t;

    tth_bt_reg_t r;
    tth_bt_reg_t next_r;
    logic [`TTH_BURST_CNT_W-1:0] last;

    always_comb begin
        last = i_double ? `TTH_BURST_CNT_W'({LEN, 1'b1}) : LEN; // RULE_03
        next_r = r;
        next_r.done = 1'b0;
        case (r.st)
            TTH_BT_IDLE: begin
                if (i_start && !i_abort) begin
                    next_r.st = TTH_BT_TONE; // RULE_01
                    next_r.cnt = '0;
                end
            end
            TTH_BT_TONE: begin
                if (i_abort) begin
                    next_r.st = TTH_BT_IDLE;
                end else if (r.cnt >= last) begin
                    next_r.st = TTH_BT_PAUSE; // RULE_01
                    next_r.cnt = '0;
                end else begin
                    next_r.cnt = r.cnt + `TTH_BURST_CNT_W'(1);
                end
            end
            TTH_BT_PAUSE: begin
                if (i_abort) begin
                    next_r.st = TTH_BT_IDLE;
                end else if (r.cnt >= last) begin
                    next_r.st = TTH_BT_IDLE;
                    next_r.done = 1'b1; // RULE_02
                end else begin
                    next_r.cnt = r.cnt + `TTH_BURST_CNT_W'(1);
                end
            end
            default: begin
                next_r.st = TTH_BT_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r <= '{st: TTH_BT_IDLE, cnt: '0, done: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign o_tone_on = (r.st == TTH_BT_TONE);
    assign o_busy = (r.st != TTH_BT_IDLE);
    assign o_done = r.done;
endmodule

// [tth_host_port.sv]
`timescale 1ns/1ps
`include "tth_regs.svh"

// Functional notes
// RULE_01 - Burst mode gives a 51 ms tone then an equal 51 ms pause per digit.
// RULE_02 - After burst and pause, status shows transmitter ready.
// RULE_03 - Call-progress mode doubles burst and pause to 102 ms.
// RULE_04 - Call-progress plus burst mode transmits only; tone-pair reception blocked.
// RULE_05 - Host times odd burst lengths itself by toggling tone output with burst off.
// RULE_06 - Single-tone mode emits one tone from the low or high group.
// RULE_07 - Status updates on its own, without host strobe activity.
// RULE_08 - Strobe-or-read low at chip-select fall selects strobe-with-direction timing.
// RULE_09 - Strobe-or-read high at chip-select fall selects separate read and write strobes.
// RULE_10 - Address and data latched at points suited to the detected bus style.
// RULE_11 - An access is decoded only after a chip-select falling edge.
// RULE_12 - Host releases chip select between accesses, one access per assertion.
// RULE_13 - Select 0 writes transmit/reads receive; select 1 writes control/reads status.
// RULE_14 - Receive data returns the last validated received digit code.
// RULE_15 - Transmit data value selects the generated tone pair.
// RULE_16 - Bank-select bit sends only the next control write to the second register.
// RULE_17 - Host software resets both control registers after power-up.
// RULE_18 - Shared pin signals interrupts or carries the call-progress square wave.
// RULE_19 - First control: b3 bank select, b2 interrupt enable, b1 call progress, b0 tone.
// RULE_20 - Second control: b3 group, b2 single/dual, b1 receiver power, b0 burst.
// RULE_21 - Tone and burst timing derive from the reference clock.
// RULE_22 - Receive-full status bit 2 clears after a status read.
// RULE_23 - New-data interrupt is removed by a status read.
// RULE_24 - Clearing tone enable powers transmitter down and clears transmit data.
// RULE_25 - Burst bit low enables burst mode, high disables it.
// RULE_26 - Transmitter ready clears on a digit write until burst and pause end.
module tth_host_port #(
    parameter int unsigned BURST_CYCLES = `TTH_BURST_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire tth_pkg::tth_bus_in_t i_bus,
    input wire tth_pkg::tth_rx_in_t i_rx,
    output logic [3:0] o_data,
    output logic o_data_oe,
    output logic o_interrupt_or_tone_out,
    output logic o_interrupt_or_tone_out_oe,
    output tth_pkg::tth_tone_ctrl_t o_tone
);
    import tth_pkg::*;

    typedef struct packed {
        logic cs_q;
        tth_style_t style;
        logic sel;
        logic open;
        logic rd_q;
        logic wr_q;
        logic [3:0] wdata;
        logic [3:0] rdata;
        logic [3:0] control_first;
        logic [3:0] control_second;
        logic [3:0] transmit_digit;
        logic [3:0] receive_digit;
        logic rx_full;
        logic irq_flag;
        logic tx_empty;
    } tth_port_reg_t;

    tth_port_reg_t r;
    tth_port_reg_t next_r;

    // Bus strobes
    logic cs_fall;
    logic rd_now;
    logic wr_now;
    logic rd_start;
    logic rd_end;
    logic wr_end;

    // Register events
    logic status_read;
    logic digit_write;
    logic ctrl_write;
    logic first_write;
    logic second_write;

    // Control fields
    logic tone_en;
    logic cp_mode;
    logic irq_en;
    logic burst_on;
    logic rx_off;
    logic rx_take;

    // Burst timer
    logic bt_start;
    logic bt_tone;
    logic bt_busy;
    logic bt_done;

    // Read sources
    logic [3:0] state_word;
    logic [3:0] read_word;

    // Access framing
    assign cs_fall = r.cs_q && !i_bus.cs_n; // RULE_11

    always_comb begin
        rd_now = 1'b0;
        wr_now = 1'b0;
        if (r.open && !i_bus.cs_n) begin
            case (r.style)
                TTH_STYLE_STROBE: begin
                    rd_now = i_bus.strobe_or_read && i_bus.rw_or_write_n; // RULE_08
                    wr_now = i_bus.strobe_or_read && !i_bus.rw_or_write_n;
                end
                TTH_STYLE_SPLIT: begin
                    rd_now = !i_bus.strobe_or_read; // RULE_09
                    wr_now = !i_bus.rw_or_write_n;
                end
                default: begin
                    rd_now = 1'b0;
                    wr_now = 1'b0;
                end
            endcase
        end
    end

    assign rd_start = rd_now && !r.rd_q;
    assign rd_end = r.rd_q && !rd_now;
    assign wr_end = r.wr_q && !wr_now;

    // Register decode; receive-full and interrupt status cleared as soon as it is captured
    always_comb begin
        status_read = 1'b0;
        digit_write = 1'b0;
        ctrl_write = 1'b0;
        if (wr_end) begin
            case (r.sel)
                `TTH_SEL_DATA: begin
                    digit_write = 1'b1; // RULE_13
                end
                `TTH_SEL_CTRL: begin
                    ctrl_write = 1'b1; // RULE_13
                end
                default: begin
                    digit_write = 1'b0;
                end
            endcase
        end else if (rd_start && (r.sel == `TTH_SEL_CTRL)) begin
            status_read = 1'b1; // RULE_22 RULE_23
        end
    end

    // Bank redirection applies to one control write only
    assign first_write = ctrl_write && !r.control_first[`TTH_CF_BANK_SEL]; // RULE_16
    assign second_write = ctrl_write && r.control_first[`TTH_CF_BANK_SEL]; // RULE_16

    // Control fields
    assign tone_en = r.control_first[`TTH_CF_TONE_OUT]; // RULE_19
    assign cp_mode = r.control_first[`TTH_CF_CP_MODE];
    assign irq_en = r.control_first[`TTH_CF_IRQ_EN];
    assign burst_on = !r.control_second[`TTH_CS_BURST_N]; // RULE_25
    assign rx_off = r.control_second[`TTH_CS_RX_PWR]; // RULE_20

    // Digits are accepted only in tone-pair receive mode
    assign rx_take = i_rx.valid && !cp_mode && !rx_off; // RULE_04

    assign bt_start = digit_write && burst_on && tone_en;

    always_comb begin
        state_word = '0;
        state_word[`TTH_ST_IRQ] = r.irq_flag; // RULE_18
        state_word[`TTH_ST_TX_EMPTY] = r.tx_empty; // RULE_02
        state_word[`TTH_ST_RX_FULL] = r.rx_full; // RULE_22
        state_word[`TTH_ST_STEER] = !i_rx.steering; // RULE_07
    end

    // Read source chosen by the latched select
    always_comb begin
        case (r.sel)
            `TTH_SEL_CTRL: begin
                read_word = state_word; // RULE_13
            end
            `TTH_SEL_DATA: begin
                read_word = r.receive_digit; // RULE_14
            end
            default: begin
                read_word = r.receive_digit;
            end
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.cs_q = i_bus.cs_n;

        // Style and select taken at the chip-select fall
        if (cs_fall) begin
            next_r.style = i_bus.strobe_or_read ? TTH_STYLE_SPLIT : TTH_STYLE_STROBE; // RULE_08 RULE_09
            next_r.sel = i_bus.register_select_line; // RULE_10
            next_r.open = 1'b1;
        end
        if (i_bus.cs_n) begin
            next_r.open = 1'b0;
        end

        next_r.rd_q = rd_now;
        next_r.wr_q = wr_now;

        // Write data follows the bus until the strobe ends
        if (wr_now) begin
            next_r.wdata = i_bus.data; // RULE_10
        end

        // Read data loaded at the start of the read strobe
        if (rd_start) begin
            next_r.rdata = read_word; // RULE_13
        end

        // One access per chip-select assertion
        if (rd_end || wr_end) begin
            next_r.open = 1'b0;
        end

        // Control writes with one-shot bank redirection
        if (first_write) begin
            next_r.control_first = r.wdata; // RULE_19
        end
        if (second_write) begin
            next_r.control_second = r.wdata; // RULE_20
            next_r.control_first[`TTH_CF_BANK_SEL] = 1'b0; // RULE_16
        end

        // Transmit digit
        if (digit_write) begin
            next_r.transmit_digit = r.wdata; // RULE_15
        end
        if (!next_r.control_first[`TTH_CF_TONE_OUT]) begin
            next_r.transmit_digit = `TTH_DIGIT_RST; // RULE_24
        end

        // Status read clears receive-full and interrupt
        if (status_read) begin
            next_r.rx_full = 1'b0; // RULE_22
            next_r.irq_flag = 1'b0; // RULE_23
        end

        // Transmitter ready
        if (bt_start) begin
            next_r.tx_empty = 1'b0; // RULE_26
        end
        if (bt_done) begin
            next_r.tx_empty = 1'b1; // RULE_02
        end
        // An aborted burst leaves the transmitter free again
        if (bt_busy && (!tone_en || !burst_on)) begin
            next_r.tx_empty = 1'b1; // RULE_24
        end

        // Hardware events win over a status-read clear
        if (rx_take) begin
            next_r.receive_digit = i_rx.code; // RULE_14
            next_r.rx_full = 1'b1; // RULE_07
            next_r.irq_flag = 1'b1; // RULE_18
        end
        if (bt_done && burst_on) begin
            next_r.irq_flag = 1'b1; // RULE_18
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r.cs_q <= 1'b1;
            r.style <= TTH_STYLE_STROBE;
            r.sel <= `TTH_SEL_DATA;
            r.open <= 1'b0;
            r.rd_q <= 1'b0;
            r.wr_q <= 1'b0;
            r.wdata <= `TTH_DIGIT_RST;
            r.rdata <= `TTH_DIGIT_RST;
            r.control_first <= `TTH_CTRL_RST;
            r.control_second <= `TTH_CTRL_RST;
            r.transmit_digit <= `TTH_DIGIT_RST;
            r.receive_digit <= `TTH_DIGIT_RST;
            r.rx_full <= 1'b0;
            r.irq_flag <= 1'b0;
            r.tx_empty <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Burst sequencer on the reference-derived clock
    tth_burst_timer #(
        .BURST_CYCLES(BURST_CYCLES)
    ) tth_burst_timer_inst (
        .i_clk(i_clk), // RULE_21
        .i_rst_n(i_rst_n),
        .i_start(bt_start), // RULE_01
        .i_abort(!tone_en || !burst_on),
        .i_double(cp_mode), // RULE_03
        .o_tone_on(bt_tone),
        .o_busy(bt_busy),
        .o_done(bt_done)
    );

    // Host data bus
    assign o_data = r.rdata;
    assign o_data_oe = r.rd_q && rd_now;

    // Open-drain pin: low while driven
    assign o_interrupt_or_tone_out = 1'b0;

    always_comb begin
        o_interrupt_or_tone_out_oe = 1'b0;
        case ({irq_en, cp_mode})
            2'b11: begin
                o_interrupt_or_tone_out_oe = !i_rx.cp_square; // RULE_18
            end
            2'b10: begin
                o_interrupt_or_tone_out_oe = r.irq_flag; // RULE_18
            end
            2'b01: begin
                o_interrupt_or_tone_out_oe = 1'b0; // RULE_19
            end
            default: begin
                o_interrupt_or_tone_out_oe = 1'b0;
            end
        endcase
    end

    // Tone generator controls
    always_comb begin
        o_tone.tx_power_down = !tone_en; // RULE_24
        o_tone.digit = r.transmit_digit; // RULE_15
        case ({tone_en, burst_on})
            2'b11: begin
                o_tone.tone_on = bt_tone; // RULE_01
            end
            2'b10: begin
                o_tone.tone_on = 1'b1; // RULE_05
            end
            2'b01: begin
                o_tone.tone_on = 1'b0; // RULE_24
            end
            default: begin
                o_tone.tone_on = 1'b0;
            end
        endcase
        o_tone.single_tone = r.control_second[`TTH_CS_SINGLE]; // RULE_06
        o_tone.high_group = r.control_second[`TTH_CS_GROUP]; // RULE_06
        o_tone.rx_power_down = rx_off;
        o_tone.call_progress = cp_mode;
    end

endmodule

// [tth_host_port_asserts.sv]
`timescale 1ns/1ps
module tth_host_port_asserts #(
    parameter int unsigned BURST_CYCLES = 20
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire tth_pkg::tth_bus_in_t i_bus,
    input wire tth_pkg::tth_rx_in_t i_rx,
    input wire logic [3:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_interrupt_or_tone_out,
    input wire logic o_interrupt_or_tone_out_oe,
    input wire tth_pkg::tth_tone_ctrl_t o_tone
);
    import tth_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_cs_fall;
        $past(i_bus.cs_n) && !i_bus.cs_n;
    endsequence
    sequence s_no_drive;
        !o_data_oe ##1 !o_data_oe;
    endsequence
    AST_PIN_LOW: assert property (o_interrupt_or_tone_out == 1'b0)
        else $error("shared pin drives high");
    AST_TONE_PD: assert property (o_tone.tone_on |-> !o_tone.tx_power_down)
        else $error("tone on while transmitter powered down");
    AST_OE_CS: assert property (o_data_oe |-> !i_bus.cs_n)
        else $error("data driven without chip select");
    AST_OE_HELD: assert property (o_data_oe |-> !$past(i_bus.cs_n) && !$past(i_bus.cs_n, 2))
        else $error("data driven too soon after chip select");
    AST_OE_NOT_AT_FALL: assert property (s_cs_fall |-> s_no_drive)
        else $error("data driven at chip select fall");
    AST_CP_SQUARE: assert property (o_tone.call_progress && o_interrupt_or_tone_out_oe |-> !i_rx.cp_square)
        else $error("pin does not follow square wave");
    AST_DATA_HOLD: assert property ($changed(o_data) |-> !i_bus.cs_n)
        else $error("read data changed outside an access");
    AST_CTRL_HOLD: assert property ($changed({o_tone.digit, o_tone.single_tone, o_tone.high_group,
        o_tone.rx_power_down, o_tone.call_progress}) |-> !$past(i_bus.cs_n))
        else $error("control changed outside an access");
    AST_RESET: assert property (disable iff (1'b0) !i_rst_n |=> o_tone.digit == 4'h0 && o_tone.tx_power_down
        && !o_tone.tone_on && !o_data_oe && !o_interrupt_or_tone_out_oe)
        else $error("outputs not reset");
    COV_FALL: cover property (s_cs_fall ##2 o_data_oe);
endmodule
bind tth_host_port tth_host_port_asserts #(.BURST_CYCLES(BURST_CYCLES)) tth_host_port_asserts_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(i_bus), .i_rx(i_rx), .o_data(o_data), .o_data_oe(o_data_oe),
    .o_interrupt_or_tone_out(o_interrupt_or_tone_out), .o_interrupt_or_tone_out_oe(o_interrupt_or_tone_out_oe),
    .o_tone(o_tone));

// [tth_rx_model.sv]
`timescale 1ns/1ps
module tth_rx_model (
    input wire logic i_clk,
    input wire logic i_fire,
    input wire logic [3:0] i_code,
    input wire logic i_steer,
    input wire logic i_square,
    output tth_pkg::tth_rx_in_t o_rx
);
    import tth_pkg::*;
    logic fired = 1'b0;
    logic [3:0] last = 4'h0;
    always @(posedge i_clk) begin
        fired <= i_fire;
        if (i_fire) begin
            last <= i_code;
        end
    end
    // Code only meaningful with the pulse
    assign o_rx = '{valid: fired, code: fired ? last : ~last, steering: i_steer, cp_square: i_square};
endmodule

// [test_tone_transceiver_host_port.sv]
`timescale 1ns/1ps
module test_tone_transceiver_host_port;
    import tth_pkg::*;
    localparam int unsigned BC = 20;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    tth_bus_in_t bus;
    logic fire = 1'b0;
    logic [3:0] code = 4'h0;
    logic steer = 1'b0;
    logic square = 1'b0;
    tth_rx_in_t rx;
    logic [3:0] rdata;
    logic oe, pin, pin_oe;
    tth_tone_ctrl_t tone;
    logic [3:0] got;
    int miscompares = 0;
    int n_checks = 0;
    int cnt, run = 0, on_len = 0;
    tth_host_port #(.BURST_CYCLES(BC)) tth_host_port_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus),
        .i_rx(rx), .o_data(rdata), .o_data_oe(oe), .o_interrupt_or_tone_out(pin),
        .o_interrupt_or_tone_out_oe(pin_oe), .o_tone(tone));
    tth_rx_model tth_rx_model_inst (.i_clk(i_clk), .i_fire(fire), .i_code(code), .i_steer(steer),
        .i_square(square), .o_rx(rx));
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    always @(negedge i_clk) begin
        if (tone.tone_on === 1'b1) begin
            run <= run + 1;
        end else begin
            if (run != 0) on_len <= run;
            run <= 0;
        end
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic access(input logic split, input logic sel, input logic rd, input logic [3:0] wd);
        @(negedge i_clk);
        bus = '{1'b0, split, 1'b1, sel, wd};
        @(negedge i_clk);
        if (split) begin
            if (rd) bus.strobe_or_read = 1'b0;
            else bus.rw_or_write_n = 1'b0;
        end else begin
            bus.strobe_or_read = 1'b1;
            bus.rw_or_write_n = rd;
        end
        repeat (2) @(negedge i_clk);
        got = rdata;
        if (rd) check({3'h0, oe}, 4'h1);
        bus.strobe_or_read = split;
        bus.rw_or_write_n = 1'b1;
        @(negedge i_clk);
        bus.cs_n = 1'b1;
        @(negedge i_clk);
    endtask
    task automatic wr(input logic split, input logic sel, input logic [3:0] d);
        access(split, sel, 1'b0, d);
    endtask
    task automatic rd(input logic split, input logic sel, input logic [3:0] exp);
        access(split, sel, 1'b1, 4'h0);
        check(got, exp);
    endtask
    task automatic fire_rx(input logic [3:0] c);
        @(negedge i_clk);
        steer = 1'b1;
        code = c;
        fire = 1'b1;
        @(negedge i_clk);
        fire = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic wait_off();
        cnt = 0;
        while (tone.tone_on !== 1'b1 && cnt < 10) begin @(negedge i_clk); cnt++; end
        while (tone.tone_on !== 1'b0 && cnt < 1000) begin @(negedge i_clk); cnt++; end
        @(negedge i_clk);
    endtask
    task automatic set_sq(input logic v);
        @(negedge i_clk);
        square = v;
        @(negedge i_clk);
        check({3'h0, pin_oe}, {3'h0, !v});
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(negedge i_clk);
        miscompares++;
        finish_test();
    end
    initial begin
        bus = '{1'b1, 1'b1, 1'b1, 1'b0, 4'h0};
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        check({2'h0, tone.tx_power_down, tone.tone_on}, 4'h2);
        rd(1'b1, 1'b1, 4'ha);
        wr(1'b0, 1'b1, 4'hd);
        wr(1'b0, 1'b1, 4'hc);
        check({tone.high_group, tone.single_tone, tone.rx_power_down, tone.tx_power_down}, 4'hc);
        wr(1'b0, 1'b1, 4'h5);
        check({tone.high_group, tone.single_tone, tone.call_progress, tone.tx_power_down}, 4'hc);
        fire_rx(4'hc);
        check({3'h0, pin_oe}, 4'h1);
        rd(1'b1, 1'b1, 4'h7);
        check({3'h0, pin_oe}, 4'h0);
        rd(1'b0, 1'b1, 4'h2);
        rd(1'b0, 1'b0, 4'hc);
        wr(1'b1, 1'b0, 4'h7);
        check(tone.digit, 4'h7);
        rd(1'b0, 1'b1, 4'h0);
        wait_off();
        check({3'h0, on_len == BC}, 4'h1);
        cnt = 0;
        while (pin_oe !== 1'b1 && cnt < 1000) begin @(negedge i_clk); cnt++; end
        check({3'h0, cnt >= BC - 2 && cnt <= BC + 2}, 4'h1);
        rd(1'b1, 1'b1, 4'h3);
        wr(1'b0, 1'b1, 4'h7);
        check({3'h0, tone.call_progress}, 4'h1);
        set_sq(1'b1);
        set_sq(1'b0);
        fire_rx(4'h3);
        rd(1'b1, 1'b0, 4'hc);
        wr(1'b1, 1'b0, 4'h9);
        wait_off();
        check({3'h0, on_len == 2 * BC}, 4'h1);
        repeat (BC + 4) @(negedge i_clk);
        access(1'b1, 1'b1, 1'b1, 4'h0);
        check(got & 4'h2, 4'h0);
        repeat (BC) @(negedge i_clk);
        access(1'b1, 1'b1, 1'b1, 4'h0);
        check(got & 4'h2, 4'h2);
        wr(1'b1, 1'b0, 4'h5);
        wr(1'b0, 1'b1, 4'h0);
        check({tone.digit[2:0], tone.tone_on}, 4'h0);
        rd(1'b1, 1'b1, 4'h2);
        wr(1'b0, 1'b1, 4'h8);
        wr(1'b0, 1'b1, 4'h1);
        wr(1'b0, 1'b1, 4'h1);
        check({3'h0, tone.tone_on}, 4'h1);
        wr(1'b0, 1'b1, 4'h0);
        check({3'h0, tone.tone_on}, 4'h0);
        wr(1'b0, 1'b1, 4'h8);
        wr(1'b0, 1'b1, 4'h3);
        check({3'h0, tone.rx_power_down}, 4'h1);
        fire_rx(4'h6);
        rd(1'b1, 1'b0, 4'hc);
        rd(1'b0, 1'b1, 4'h2);
        finish_test();
    end
endmodule
